// file: codec_ctl_host.sv
// host end: software port that issues codec instructions and keeps read-back
`timescale 1ns/10ps
`default_nettype none
module codec_ctl_host
  import codec_regs_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [2:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rd_data,
  codec_ctl_if.host ctl
);
  logic [7:0] byte2_reg; // staged second byte
  logic [7:0] last_b1_reg; // last first byte issued
  logic instr_valid_reg; // instruction pulse
  logic [7:0] instr_b1_reg; // first byte driven out
  logic [7:0] instr_b2_reg; // second byte driven out
  logic [7:0] readback_reg; // last read-back byte
  logic readback_new_reg; // sticky: read-back arrived, unread
  logic readback_rd; // software reads the read-back byte

  assign readback_rd = rd_en && addr == HOST_OFS_READBACK;

  // stage byte two, issue with byte one written at the issue offset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      byte2_reg <= 8'h00;
      last_b1_reg <= 8'h00;
      instr_valid_reg <= 1'b0;
      instr_b1_reg <= 8'h00;
      instr_b2_reg <= 8'h00;
    end else begin
      instr_valid_reg <= 1'b0;
      if (wr_en && addr == HOST_OFS_BYTE2) begin
        byte2_reg <= wr_data;
      end
      // software clears bit one itself for the single byte power order
      if (wr_en && addr == HOST_OFS_ISSUE) begin
        instr_valid_reg <= 1'b1;
        instr_b1_reg <= wr_data;
        instr_b2_reg <= byte2_reg;
        last_b1_reg <= wr_data;
      end
    end
  end

  // capture read-back; arrival wins over a read in the same cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      readback_reg <= 8'h00;
      readback_new_reg <= 1'b0;
    end else if (ctl.rsp_valid) begin
      readback_reg <= ctl.rsp_data;
      readback_new_reg <= 1'b1;
    end else if (readback_rd) begin
      readback_new_reg <= 1'b0;
    end
  end

  // read data one cycle after the strobe, zero for unmapped offsets
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_data <= 8'h00;
    end else if (rd_en) begin
      unique case (addr)
        HOST_OFS_BYTE2: rd_data <= byte2_reg;
        HOST_OFS_STATUS: rd_data <= {7'h00, readback_new_reg};
        HOST_OFS_READBACK: rd_data <= readback_reg;
        HOST_OFS_LAST_B1: rd_data <= last_b1_reg;
        default: rd_data <= 8'h00;
      endcase
    end else begin
      rd_data <= 8'h00;
    end
  end

  assign ctl.instr_valid = instr_valid_reg;
  assign ctl.instr_b1 = instr_b1_reg;
  assign ctl.instr_b2 = instr_b2_reg;
endmodule : codec_ctl_host
`default_nettype wire

// file: codec_ctl_if.sv
// instruction carrier between the host end and the codec register bank
`timescale 1ns/10ps
`default_nettype none
interface codec_ctl_if;
  logic instr_valid; // one cycle pulse, bytes below are valid
  logic [7:0] instr_b1; // first byte
  logic [7:0] instr_b2; // second byte, used when two-byte bit set
  logic rsp_valid; // one cycle pulse, read-back byte valid
  logic [7:0] rsp_data; // read-back second byte
  modport device (input instr_valid, input instr_b1, input instr_b2,
                  output rsp_valid, output rsp_data);
  modport host (output instr_valid, output instr_b1, output instr_b2,
                input rsp_valid, input rsp_data);
endinterface : codec_ctl_if
`default_nettype wire

// file: codec_link_chk.sv
// assertions on the instruction link between host end and register bank
`timescale 1ns/10ps
`default_nettype none
module codec_link_chk
  import codec_regs_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic instr_valid,
  input wire logic [7:0] instr_b1,
  input wire logic [7:0] instr_b2,
  input wire logic rsp_valid,
  input wire logic [7:0] rsp_data
);
  logic rd_now; // read instruction taken now
  logic wr_now; // two-byte write taken now
  logic rd_p_reg; // read taken last cycle
  logic [7:0] setup_reg; // shadow of the setup byte
  logic [7:0] dir_reg; // shadow of the direction byte
  assign rd_now = instr_valid && instr_b1[2] && instr_b1[1];
  assign wr_now = instr_valid && !instr_b1[2] && instr_b1[1];
  // shadows follow two-byte writes only
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_p_reg <= 1'b0;
      setup_reg <= SETUP_RESET;
      dir_reg <= LATCH_DIR_RESET;
    end else begin
      rd_p_reg <= rd_now;
      if (wr_now && instr_b1[6:3] == ADDR_SETUP) setup_reg <= instr_b2;
      if (wr_now && instr_b1[6:3] == ADDR_LATCH_DIR) dir_reg <= instr_b2;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // a read taken, optionally at one address
  sequence s_read;
    rd_now;
  endsequence
  sequence s_read_at(logic [3:0] a);
    rd_now ##0 (instr_b1[6:3] == a);
  endsequence
  a_read_answer: assert property (s_read |=> rsp_valid)
    else $error("read not answered");
  a_no_stray: assert property (rsp_valid |-> $past(rd_now))
    else $error("answer without read");
  a_rsp_pulse: assert property (rsp_valid |=> (rsp_valid == rd_p_reg))
    else $error("answer pulse too long");
  a_rsp_hold: assert property (!rsp_valid |-> $stable(rsp_data))
    else $error("answer byte moved");
  a_setup_echo: assert property (s_read_at(ADDR_SETUP) |=> rsp_data == setup_reg)
    else $error("setup read mismatch");
  a_dir_echo: assert property (s_read_at(ADDR_LATCH_DIR) |=> rsp_data == {dir_reg[7:2], 2'b00})
    else $error("direction read mismatch");
  a_latch_low: assert property (s_read_at(ADDR_LATCH_VALUE) |=> rsp_data[1:0] == 2'b00)
    else $error("latch low bits set");
  a_bad_zero: assert property (s_read ##0 (instr_b1[6:3] > 4'h2) |=> rsp_data == 8'h00)
    else $error("unknown read not zero");
endmodule // codec_link_chk
`default_nettype wire

// file: codec_regs_pkg.sv
// shared constants and types for the codec setup and latch register bank
package codec_regs_pkg;
  // first byte fields
  localparam int B1_POWER_BIT = 7;
  localparam int B1_ADDR_HI = 6;
  localparam int B1_ADDR_LO = 3;
  localparam int B1_READ_BIT = 2;
  localparam int B1_TWO_BYTE_BIT = 1;
  // register address codes in first byte bits 6..3
  localparam logic [3:0] ADDR_SETUP = 4'h0;
  localparam logic [3:0] ADDR_LATCH_VALUE = 4'h1;
  localparam logic [3:0] ADDR_LATCH_DIR = 4'h2;
  // setup byte field positions
  localparam int SETUP_RATE_HI = 7;
  localparam int SETUP_RATE_LO = 6;
  localparam int SETUP_LAW = 5;
  localparam int SETUP_INV = 4;
  localparam int SETUP_TIMING = 3;
  localparam int SETUP_PCM_RET = 2;
  localparam int SETUP_CONV_RET = 1;
  localparam int SETUP_AMP_SLEEP = 0;
  // reset values: 2.048 MHz, mu-255, non-delayed, normal, amp off in sleep
  localparam logic [7:0] SETUP_RESET = 8'h89;
  localparam logic [7:0] LATCH_DIR_RESET = 8'h00;
  localparam logic [7:0] LATCH_VALUE_RESET = 8'h00;
  localparam logic SLEEP_RESET = 1'b1;
  // latch layout: latch i sits at byte bit (LATCH_TOP - i)
  localparam int LATCH_TOP = 7;
  localparam int LATCH_COUNT = 4;
  localparam int LATCH_BITS_KEPT = 6;
  // wake holdoff counts frame sync pulses
  localparam logic [1:0] WAKE_SYNC_COUNT = 2'h2;
  // host user-port register offsets
  localparam logic [2:0] HOST_OFS_BYTE2 = 3'h0;
  localparam logic [2:0] HOST_OFS_ISSUE = 3'h1;
  localparam logic [2:0] HOST_OFS_STATUS = 3'h2;
  localparam logic [2:0] HOST_OFS_READBACK = 3'h3;
  localparam logic [2:0] HOST_OFS_LAST_B1 = 3'h4;
  // master clock divider choice
  typedef enum logic [1:0] {
    RATE_512K = 2'h0,
    RATE_1536K = 2'h1,
    RATE_2048K = 2'h2,
    RATE_4096K = 2'h3
  } rate_sel_t;
  // coding law choice
  typedef enum logic [1:0] {
    LAW_MU255,
    LAW_A_EVEN_INV,
    LAW_A_PLAIN
  } law_mode_t;
  // loopback choice
  typedef enum logic [1:0] {
    LOOP_NORMAL,
    LOOP_DIGITAL,
    LOOP_ANALOG
  } loop_mode_t;
endpackage : codec_regs_pkg

// file: codec_setup_and_latch_regs.sv
// codec register bank: setup, power state, latch direction and values
`timescale 1ns/10ps
`default_nettype none
module codec_setup_and_latch_regs
  import codec_regs_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  codec_ctl_if.device ctl,
  input wire logic tx_frame_sync,
  input wire logic [LATCH_COUNT-1:0] latch_pin_in,
  output logic [LATCH_COUNT-1:0] latch_pin_out,
  output logic [LATCH_COUNT-1:0] latch_pin_oe,
  output logic sleep_state,
  output rate_sel_t rate_sel,
  output law_mode_t law_mode,
  output logic timing_style_sel,
  output loop_mode_t loop_mode,
  output logic tx_voice_in_isolated,
  output logic amp_on,
  output logic tx_pcm_enable
);
  logic [7:0] codec_setup_reg; // setup byte as written
  logic [LATCH_BITS_KEPT-1:0] latch_dir_reg; // direction bits 7..2
  logic [LATCH_BITS_KEPT-1:0] latch_value_reg; // written latch data 7..2
  logic sleep_reg; // power state, one is asleep
  logic [1:0] wake_sync_reg; // frame syncs seen since waking
  logic fs_prev_reg; // last frame sync level
  logic rsp_valid_reg; // read-back pulse
  logic [7:0] rsp_data_reg; // read-back byte
  logic is_two; // instruction carries a second byte
  logic is_read; // instruction reads back
  logic [3:0] addr; // register address code
  logic fs_rise; // frame sync rising edge
  logic [7:0] latch_read; // assembled latch state byte

  // a two-byte write instruction aimed at one register address
  function automatic logic write_hit(
    input logic valid,
    input logic [7:0] b1,
    input logic [3:0] want
  );
    return valid && b1[B1_TWO_BYTE_BIT] && !b1[B1_READ_BIT] &&
      (b1[B1_ADDR_HI:B1_ADDR_LO] == want);
  endfunction

  // latch i keeps its bit at this index of a kept field
  function automatic int kept_index(input int latch);
    return LATCH_BITS_KEPT - 1 - latch;
  endfunction

  // the kept upper bits of a latch byte; the two low bits are don't-care
  function automatic logic [LATCH_BITS_KEPT-1:0] kept_bits(input logic [7:0] b);
    return b[7:8-LATCH_BITS_KEPT];
  endfunction

  // decode the first byte
  assign is_two = ctl.instr_b1[B1_TWO_BYTE_BIT];
  assign is_read = ctl.instr_b1[B1_READ_BIT];
  assign addr = ctl.instr_b1[B1_ADDR_HI:B1_ADDR_LO];
  assign fs_rise = tx_frame_sync & ~fs_prev_reg;

  // pin level for inputs, written value for outputs
  always_comb begin
    latch_read = 8'h00;
    for (int i = 0; i < LATCH_COUNT; i++) begin
      latch_read[LATCH_TOP-i] = latch_dir_reg[LATCH_BITS_KEPT-1-i] ?
        latch_value_reg[LATCH_BITS_KEPT-1-i] : latch_pin_in[i];
    end
    for (int j = LATCH_COUNT; j < LATCH_BITS_KEPT; j++) begin
      latch_read[LATCH_TOP-j] = latch_value_reg[LATCH_BITS_KEPT-1-j];
    end
  end

  // every instruction carries the power bit, whatever its kind
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sleep_reg <= SLEEP_RESET;
    end else if (ctl.instr_valid) begin
      sleep_reg <= ctl.instr_b1[B1_POWER_BIT];
    end
  end

  // setup register write, in either power state
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      codec_setup_reg <= SETUP_RESET;
    end else if (write_hit(ctl.instr_valid, ctl.instr_b1, ADDR_SETUP)) begin
      codec_setup_reg <= ctl.instr_b2;
    end
  end

  // latch direction write, bits 1 and 0 dropped
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      latch_dir_reg <= LATCH_DIR_RESET[LATCH_BITS_KEPT-1:0];
    end else if (write_hit(ctl.instr_valid, ctl.instr_b1, ADDR_LATCH_DIR)) begin
      latch_dir_reg <= kept_bits(ctl.instr_b2);
    end
  end

  // latch value write
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      latch_value_reg <= LATCH_VALUE_RESET[LATCH_BITS_KEPT-1:0];
    end else if (write_hit(ctl.instr_valid, ctl.instr_b1, ADDR_LATCH_VALUE)) begin
      latch_value_reg <= kept_bits(ctl.instr_b2);
    end
  end

  // read-back answer one cycle after the instruction
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rsp_valid_reg <= 1'b0;
      rsp_data_reg <= 8'h00;
    end else begin
      rsp_valid_reg <= 1'b0;
      if (ctl.instr_valid && is_two && is_read) begin
        rsp_valid_reg <= 1'b1;
        unique case (addr)
          ADDR_SETUP: rsp_data_reg <= codec_setup_reg;
          ADDR_LATCH_VALUE: rsp_data_reg <= latch_read;
          ADDR_LATCH_DIR: rsp_data_reg <= {latch_dir_reg, 2'b00};
          default: rsp_data_reg <= 8'h00; // invalid codes read zero
        endcase
      end
    end
  end

  // count frame syncs after waking; sleep restarts the count
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fs_prev_reg <= 1'b0;
      wake_sync_reg <= 2'h0;
    end else begin
      fs_prev_reg <= tx_frame_sync;
      if (sleep_reg) begin
        wake_sync_reg <= 2'h0;
      // the count saturates once the holdoff is over
      end else if (fs_rise && wake_sync_reg != WAKE_SYNC_COUNT) begin
        wake_sync_reg <= wake_sync_reg + 2'h1;
      end
    end
  end

  // power outputs follow the sleep state and the wake holdoff
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sleep_state <= SLEEP_RESET; // asleep after power-on
      amp_on <= 1'b0; // amp disabled in sleep by default
      tx_pcm_enable <= 1'b0; // pcm output held off
    end else begin
      sleep_state <= sleep_reg;
      // amp stays on in sleep only while the amp-in-sleep bit is clear
      amp_on <= !sleep_reg || !codec_setup_reg[SETUP_AMP_SLEEP];
      // pcm output waits for the second frame sync after waking
      tx_pcm_enable <= !sleep_reg && (wake_sync_reg == WAKE_SYNC_COUNT);
    end
  end

  // setup byte fields decoded into mode outputs
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rate_sel <= RATE_2048K;
      law_mode <= LAW_MU255;
      timing_style_sel <= 1'b1;
      loop_mode <= LOOP_NORMAL;
      tx_voice_in_isolated <= 1'b0;
    end else begin
      rate_sel <= rate_sel_t'(codec_setup_reg[SETUP_RATE_HI:SETUP_RATE_LO]);
      // mu-255 whenever law bit is zero
      if (!codec_setup_reg[SETUP_LAW]) begin
        law_mode <= LAW_MU255;
      end else if (!codec_setup_reg[SETUP_INV]) begin
        law_mode <= LAW_A_EVEN_INV;
      end else begin
        law_mode <= LAW_A_PLAIN;
      end
      timing_style_sel <= codec_setup_reg[SETUP_TIMING];
      // digital loop wins over analog loop
      if (codec_setup_reg[SETUP_PCM_RET]) begin
        loop_mode <= LOOP_DIGITAL;
      end else if (codec_setup_reg[SETUP_CONV_RET]) begin
        loop_mode <= LOOP_ANALOG;
      end else begin
        loop_mode <= LOOP_NORMAL;
      end
      // voice input cut from its pin only in analog loop
      tx_voice_in_isolated <= !codec_setup_reg[SETUP_PCM_RET] &&
        codec_setup_reg[SETUP_CONV_RET];
    end
  end

  // latch pins: all inputs after reset, then direction and data bits
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      latch_pin_out <= '0;
      latch_pin_oe <= '0;
    end else begin
      for (int i = 0; i < LATCH_COUNT; i++) begin
        latch_pin_oe[i] <= latch_dir_reg[kept_index(i)];
        latch_pin_out[i] <= latch_value_reg[kept_index(i)];
      end
    end
  end

  assign ctl.rsp_valid = rsp_valid_reg;
  assign ctl.rsp_data = rsp_data_reg;
endmodule : codec_setup_and_latch_regs
`default_nettype wire

// file: codec_setup_and_latch_regs_tb.sv
// self-checking bench for the host end and register bank pair
`timescale 1ns/10ps
`default_nettype none
module codec_setup_and_latch_regs_tb;
  import codec_regs_pkg::*;
  logic clk, rst_n, wr_en, rd_en, fs, rd_q, sleep, tst, iso, amp, pcm;
  logic [2:0] addr;
  logic [7:0] wr_data, rd_data, b, v, d, p, eo, er;
  logic [3:0] pin_in, pin_out, pin_oe;
  logic [1:0] la, lp;
  rate_sel_t rate;
  law_mode_t law;
  loop_mode_t lpm;
  int num_errors, comparisons, cyc;
  logic [31:0] seed;
  logic [7:0] exp_q[$]; // expected user port read bytes
  codec_ctl_if ctl();
  codec_setup_and_latch_regs codec_setup_and_latch_regs_inst(.clk(clk), .rst_n(rst_n),
    .ctl(ctl), .tx_frame_sync(fs), .latch_pin_in(pin_in), .latch_pin_out(pin_out),
    .latch_pin_oe(pin_oe), .sleep_state(sleep), .rate_sel(rate), .law_mode(law),
    .timing_style_sel(tst), .loop_mode(lpm), .tx_voice_in_isolated(iso), .amp_on(amp),
    .tx_pcm_enable(pcm));
  codec_ctl_host codec_ctl_host_inst(.clk(clk), .rst_n(rst_n), .addr(addr),
    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .ctl(ctl));
  codec_link_chk codec_link_chk_inst(.clk(clk), .rst_n(rst_n), .instr_valid(ctl.instr_valid),
    .instr_b1(ctl.instr_b1), .instr_b2(ctl.instr_b2), .rsp_valid(ctl.rsp_valid),
    .rsp_data(ctl.rsp_data));
  // clock, 50 ns period
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // xorshift step for random bytes
  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction
  // byte compare with report
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  // user port write and read, one strobe cycle then one idle edge
  task automatic wr(input logic [2:0] a, input logic [7:0] x);
    addr <= a;
    wr_data <= x;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    @(posedge clk);
  endtask
  // stage second byte, issue first, let outputs settle
  task automatic cmd(input logic [7:0] b1, input logic [7:0] b2);
    wr(HOST_OFS_BYTE2, b2);
    wr(HOST_OFS_ISSUE, b1);
    repeat (3) @(posedge clk);
  endtask
  // one frame sync pulse
  task automatic fsync();
    fs <= 1'b1;
    @(posedge clk);
    fs <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  task automatic test_done();
    if (exp_q.size() != 0) num_errors++; // reads never answered
    $display("comparisons %0d num_errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // read data stands the cycle after the strobe
  always @(posedge clk) begin
    rd_q <= rd_en;
    if (rd_q) chk("rd_data", exp_q.pop_front(), rd_data);
  end
  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 8000) begin
      num_errors++;
      test_done();
    end
  end
  initial begin
    {rst_n, wr_en, rd_en, fs, addr, wr_data, pin_in} = '0;
    seed = 32'hB24DB4BC;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    chk("mode", {rate, law, tst, lpm, amp}, 8'h88);
    chk("pwr", 8'({sleep, pcm, pin_oe}), 8'h20);
    cmd(8'h86, 8'h00);
    rd(HOST_OFS_STATUS, 8'h01);
    rd(HOST_OFS_READBACK, SETUP_RESET);
    rd(HOST_OFS_STATUS, 8'h00);
    rd(HOST_OFS_LAST_B1, 8'h86);
    rd(HOST_OFS_BYTE2, 8'h00);
    rd(3'h7, 8'h00);
    $display("test reset done");
    for (int i = 0; i < 64; i++) begin
      seed = xs(seed);
      b = {i[1:0], i[3:2], seed[0], i[5:4], seed[1]};
      cmd(8'h82, b);
      la = !b[5] ? 2'h0 : (b[4] ? 2'h2 : 2'h1);
      lp = b[2] ? 2'h1 : (b[1] ? 2'h2 : 2'h0);
      chk("mode", {rate, law, tst, lpm, amp}, {b[7:6], la, b[3], lp, !b[0]});
      chk("iso", 8'(iso), 8'(lp == 2'h2));
      cmd(8'h86, 8'h00);
      rd(HOST_OFS_READBACK, b);
    end
    $display("test setup done");
    cmd(8'h00, 8'h00);
    chk("wake", 8'({sleep, pcm, amp}), 8'h01);
    fsync();
    chk("pcm", 8'(pcm), 8'h00);
    fsync();
    chk("pcm", 8'(pcm), 8'h01);
    cmd(8'h06, 8'h00);
    rd(HOST_OFS_READBACK, b);
    cmd(8'h80, 8'h00);
    chk("sleep", 8'({sleep, pcm}), 8'h02);
    $display("test power done");
    for (int j = 0; j < 4; j++) begin
      seed = xs(seed);
      v = seed[7:0];
      d = {seed[11:8], 4'hC};
      p = {4'h0, seed[15:12]};
      pin_in <= p[3:0];
      cmd(8'h8A, v);
      cmd(8'h92, d);
      eo = '0;
      er = {4'h0, v[3:2], 2'b00};
      for (int k = 0; k < 4; k++) begin
        eo[k] = d[7-k];
        er[7-k] = d[7-k] ? v[7-k] : p[k];
      end
      chk("oe", 8'(pin_oe), eo);
      chk("out", 8'(pin_out & pin_oe), {4'h0, v[4], v[5], v[6], v[7]} & eo);
      cmd(8'h8E, 8'h00);
      rd(HOST_OFS_READBACK, er);
      cmd(8'h96, 8'h00);
      rd(HOST_OFS_READBACK, {d[7:2], 2'b00});
    end
    cmd(8'hFE, 8'h00);
    rd(HOST_OFS_READBACK, 8'h00);
    $display("test latch done");
    repeat (2) @(posedge clk);
    test_done();
  end
endmodule // codec_setup_and_latch_regs_tb
`default_nettype wire
